// ---- common/toe_pkg.sv ----
// constants for the transfer instruction executor
package toe_pkg;
    localparam int unsigned toe_op_width = 10;
    localparam int unsigned toe_nib = 4;
    localparam int unsigned toe_byte = 8;
    localparam int unsigned toe_tmr_count = 6;
    localparam int unsigned toe_ram_addr_width = 10;
    // opcodes of the group
    localparam logic [9:0] toe_op_reload_three = 10'h23b;
    localparam logic [9:0] toe_op_serial_shift = 10'h238;
    localparam logic [9:0] toe_op_irq_one = 10'h03f;
    localparam logic [9:0] toe_op_irq_two = 10'h03e;
    localparam logic [9:0] toe_op_tmr_one = 10'h20e;
    localparam logic [9:0] toe_op_tmr_two = 10'h20f;
    localparam logic [9:0] toe_op_tmr_three = 10'h210;
    localparam logic [9:0] toe_op_tmr_four = 10'h211;
    localparam logic [9:0] toe_op_tmr_five = 10'h212;
    localparam logic [9:0] toe_op_tmr_six = 10'h213;
    localparam logic [9:0] toe_op_wdog_test = 10'h2a0;
    localparam logic [9:0] toe_op_wdog_disable = 10'h29c;
    // upper six bits of the exchange forms, j in the low nibble
    localparam logic [5:0] toe_op_swap = 6'h2d;
    localparam logic [5:0] toe_op_swap_dec = 6'h2f;
    localparam logic [5:0] toe_op_swap_inc = 6'h2e;
    localparam logic [3:0] toe_y_wrap_dec = 4'hf;
    localparam logic [3:0] toe_y_wrap_inc = 4'h0;
    localparam logic [3:0] toe_y_step = 4'h1;
    localparam logic [3:0] toe_nib_reset = 4'h0;
    localparam logic [7:0] toe_byte_reset = 8'h00;
endpackage : toe_pkg

// ---- hw/toe_exec.sv ----
// executor for the peripheral transfer and ram exchange instructions
// Summary of operation
// - the reload-three pair load writes B to the high nibble and A to the low nibble of reload register three at once.
// - the serial shift pair load writes B to bits seven to four and A to bits three to zero of the shift register.
// - each of the six timer control writes copies A into its own control register with no carry change and no skip.
// - the watchdog test skips the next instruction when the overflow flag is 1, else runs on, and clears the flag unless an overflow is set in the same cycle.
// - the watchdog test executed right after the watchdog disable op stops the watchdog timer.
// - the plain swap exchanges A with ram at the data pointer and sets X to X xor j.
// - the swap with decrement also decrements Y and skips only when Y becomes 15.
// - the swap with increment also increments Y and skips only when Y becomes 0.
//
// The register offsets and strobed register access were decided locally.
module toe_exec
    import toe_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic op_valid,
    input wire logic [toe_op_width-1:0] op_code,
    input wire logic [toe_nib-1:0] acc_in,
    input wire logic [toe_nib-1:0] reg_b_in,
    input wire logic [toe_nib-1:0] reg_x_in,
    input wire logic [toe_nib-1:0] reg_y_in,
    input wire logic [toe_ram_addr_width-1:0] data_pointer,
    input wire logic [toe_nib-1:0] ram_rdata,
    input wire logic watchdog_overflow_set,
    output logic done,
    output logic skip_next,
    output logic acc_we,
    output logic [toe_nib-1:0] acc_out,
    output logic xy_we,
    output logic [toe_nib-1:0] reg_x_out,
    output logic [toe_nib-1:0] reg_y_out,
    output logic ram_we,
    output logic [toe_ram_addr_width-1:0] ram_addr,
    output logic [toe_nib-1:0] ram_wdata,
    output logic [toe_byte-1:0] reload_reg_three,
    output logic reload_three_load,
    output logic [toe_byte-1:0] serial_shift,
    output logic serial_shift_load,
    output logic [toe_nib-1:0] irq_ctrl_one,
    output logic [toe_nib-1:0] irq_ctrl_two,
    output logic [toe_tmr_count*toe_nib-1:0] tmr_ctrl,
    output logic watchdog_overflow_flag,
    output logic watchdog_stopped
);
    typedef struct packed {
        logic done;
        logic skip_next;
        logic acc_we;
        logic [toe_nib-1:0] acc_out;
        logic xy_we;
        logic [toe_nib-1:0] x;
        logic [toe_nib-1:0] y;
        logic ram_we;
        logic [toe_ram_addr_width-1:0] ram_addr;
        logic [toe_nib-1:0] ram_wdata;
        logic [toe_byte-1:0] reload3;
        logic reload3_ld;
        logic [toe_byte-1:0] sio;
        logic sio_ld;
        logic [toe_nib-1:0] irq1;
        logic [toe_nib-1:0] irq2;
        logic [toe_tmr_count*toe_nib-1:0] tmr;
        logic wdf;
        logic wd_stop;
        logic last_disable;
    } toe_state_type;

    toe_state_type st;
    toe_state_type next_st;

    // per timer control register match and next value
    logic [toe_tmr_count-1:0] tmr_hit;
    logic [toe_tmr_count*toe_nib-1:0] tmr_next;

    // immediate field and opcode class field
    logic [toe_nib-1:0] j_imm;
    logic [toe_op_width-toe_nib-1:0] op_hi;

    // instruction decode, before qualification by op_valid
    logic is_reload3;
    logic is_serial;
    logic is_irq1;
    logic is_irq2;
    logic is_wdog_test;
    logic is_wdog_disable;
    logic is_swap_plain;
    logic is_swap_dec;
    logic is_swap_inc;
    logic is_swap_any;
    logic is_tmr_any;
    logic is_group;

    // decode qualified by a valid instruction in this cycle
    logic en_reload3;
    logic en_serial;
    logic en_irq1;
    logic en_irq2;
    logic en_wdog_test;
    logic en_swap_any;
    logic en_swap_dec;
    logic en_swap_inc;

    // exchange datapath
    logic [toe_byte-1:0] pair_word;
    logic [toe_nib-1:0] x_new;
    logic [toe_nib-1:0] y_dec;
    logic [toe_nib-1:0] y_inc;
    logic skip_dec;
    logic skip_inc;

    // watchdog flag and stop
    logic wdf_clear;
    logic wdf_next;
    logic wd_stop_next;

    assign j_imm = op_code[toe_nib-1:0];
    assign op_hi = op_code[toe_op_width-1:toe_nib];

    assign is_reload3 = op_code == toe_op_reload_three;
    assign is_serial = op_code == toe_op_serial_shift;
    assign is_irq1 = op_code == toe_op_irq_one;
    assign is_irq2 = op_code == toe_op_irq_two;
    assign is_wdog_test = op_code == toe_op_wdog_test;
    assign is_wdog_disable = op_code == toe_op_wdog_disable;
    assign is_swap_plain = op_hi == toe_op_swap;
    assign is_swap_dec = op_hi == toe_op_swap_dec;
    assign is_swap_inc = op_hi == toe_op_swap_inc;
    assign is_swap_any = is_swap_plain | is_swap_dec | is_swap_inc;
    assign is_tmr_any = |tmr_hit;
    assign is_group = is_reload3 | is_serial | is_irq1 | is_irq2 | is_wdog_test | is_swap_any | is_tmr_any;

    assign en_reload3 = op_valid & is_reload3;
    assign en_serial = op_valid & is_serial;
    assign en_irq1 = op_valid & is_irq1;
    assign en_irq2 = op_valid & is_irq2;
    assign en_wdog_test = op_valid & is_wdog_test;
    assign en_swap_any = op_valid & is_swap_any;
    assign en_swap_dec = op_valid & is_swap_dec;
    assign en_swap_inc = op_valid & is_swap_inc;

    assign pair_word = {reg_b_in, acc_in};
    assign x_new = reg_x_in ^ j_imm;
    assign y_dec = reg_y_in - toe_y_step;
    assign y_inc = reg_y_in + toe_y_step;
    assign skip_dec = y_dec == toe_y_wrap_dec;
    assign skip_inc = y_inc == toe_y_wrap_inc;

    // the test clears only a set flag; an overflow in the same cycle wins
    assign wdf_clear = en_wdog_test & st.wdf;
    assign wdf_next = watchdog_overflow_set | (st.wdf & ~wdf_clear);
    // the stop is sticky until reset
    assign wd_stop_next = st.wd_stop | (en_wdog_test & st.last_disable);

    genvar gi;
    generate
        for (gi = 0; gi < toe_tmr_count; gi++) begin : g_tmr
            assign tmr_hit[gi] = op_code == (toe_op_tmr_one + 10'(gi));
            assign tmr_next[gi*toe_nib +: toe_nib] = (op_valid && tmr_hit[gi]) ? acc_in
                : st.tmr[gi*toe_nib +: toe_nib];
        end
    endgenerate

    always_comb begin
        next_st = st;

        // pulses last one cycle
        next_st.done = 1'b0;
        next_st.skip_next = 1'b0;
        next_st.acc_we = 1'b0;
        next_st.xy_we = 1'b0;
        next_st.ram_we = 1'b0;
        next_st.reload3_ld = 1'b0;
        next_st.sio_ld = 1'b0;

        // level registers
        next_st.tmr = tmr_next;
        next_st.wdf = wdf_next;
        next_st.wd_stop = wd_stop_next;

        // any valid instruction updates the disable memory
        if (op_valid) begin
            next_st.done = is_group;
            next_st.last_disable = is_wdog_disable;
        end

        if (en_reload3) begin
            next_st.reload3 = pair_word;
            next_st.reload3_ld = 1'b1;
        end

        if (en_serial) begin
            next_st.sio = pair_word;
            next_st.sio_ld = 1'b1;
        end

        if (en_irq1) begin
            next_st.irq1 = acc_in;
        end

        if (en_irq2) begin
            next_st.irq2 = acc_in;
        end

        // skip uses the flag as it stood before this cycle
        if (en_wdog_test) begin
            next_st.skip_next = st.wdf;
        end

        // old accumulator goes to ram, ram nibble to the accumulator
        if (en_swap_any) begin
            next_st.acc_we = 1'b1;
            next_st.acc_out = ram_rdata;
            next_st.ram_we = 1'b1;
            next_st.ram_addr = data_pointer;
            next_st.ram_wdata = acc_in;
            next_st.xy_we = 1'b1;
            next_st.x = x_new;
            next_st.y = reg_y_in;
        end

        if (en_swap_dec) begin
            next_st.y = y_dec;
            next_st.skip_next = skip_dec;
        end

        if (en_swap_inc) begin
            next_st.y = y_inc;
            next_st.skip_next = skip_inc;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign done = st.done;
    assign skip_next = st.skip_next;
    assign acc_we = st.acc_we;
    assign acc_out = st.acc_out;
    assign xy_we = st.xy_we;
    assign reg_x_out = st.x;
    assign reg_y_out = st.y;
    assign ram_we = st.ram_we;
    assign ram_addr = st.ram_addr;
    assign ram_wdata = st.ram_wdata;
    assign reload_reg_three = st.reload3;
    assign reload_three_load = st.reload3_ld;
    assign serial_shift = st.sio;
    assign serial_shift_load = st.sio_ld;
    assign irq_ctrl_one = st.irq1;
    assign irq_ctrl_two = st.irq2;
    assign tmr_ctrl = st.tmr;
    assign watchdog_overflow_flag = st.wdf;
    assign watchdog_stopped = st.wd_stop;
endmodule // toe_exec

// ---- testbench/toe_exec_properties.sv ----
// assertions on the ports of the transfer instruction executor
module toe_exec_properties
    import toe_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic op_valid,
    input wire logic done,
    input wire logic skip_next,
    input wire logic watchdog_overflow_set,
    input wire logic watchdog_overflow_flag,
    input wire logic watchdog_stopped,
    input wire logic [9:0] op_code,
    input wire logic [3:0] acc_in,
    input wire logic [3:0] reg_b_in,
    input wire logic [3:0] reg_x_in,
    input wire logic [3:0] reg_y_in,
    input wire logic [3:0] ram_rdata,
    input wire logic [3:0] acc_out,
    input wire logic [3:0] reg_x_out,
    input wire logic [3:0] reg_y_out,
    input wire logic [3:0] irq_ctrl_one,
    input wire logic [7:0] reload_reg_three,
    input wire logic [7:0] serial_shift,
    input wire logic [23:0] tmr_ctrl
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire [7:0] pair = {reg_b_in, acc_in};
    wire [3:0] x_new = reg_x_in ^ op_code[3:0];
    wire [3:0] y_dec = reg_y_in - 4'h1;
    wire [3:0] y_inc = reg_y_in + 4'h1;
    sequence s_op(logic [9:0] c); op_valid && op_code == c; endsequence
    sequence s_sw(logic [5:0] c); op_valid && op_code[9:4] == c; endsequence
    a_reload_pair: assert property (s_op(toe_op_reload_three) |=> reload_reg_three == $past(pair))
        else $error("reload pair wrong");
    a_serial_pair: assert property (s_op(toe_op_serial_shift) |=> serial_shift == $past(pair))
        else $error("serial pair wrong");
    a_tmr_write: assert property (s_op(toe_op_tmr_one) |=> tmr_ctrl[3:0] == $past(acc_in) && !skip_next)
        else $error("timer control wrong");
    a_irq_write: assert property (s_op(toe_op_irq_one) |=> irq_ctrl_one == $past(acc_in) && !skip_next)
        else $error("irq control wrong");
    a_wdog_skip: assert property (s_op(toe_op_wdog_test) |=> skip_next == $past(watchdog_overflow_flag))
        else $error("watchdog skip wrong");
    a_wdog_clear: assert property (s_op(toe_op_wdog_test) && !watchdog_overflow_set |=> !watchdog_overflow_flag)
        else $error("watchdog flag kept");
    a_wdog_stop: assert property (s_op(toe_op_wdog_disable) ##1 s_op(toe_op_wdog_test) |=> watchdog_stopped)
        else $error("watchdog not stopped");
    a_swap_plain: assert property (s_sw(toe_op_swap) |=> acc_out == $past(ram_rdata) && reg_x_out == $past(x_new))
        else $error("swap wrong");
    a_swap_dec: assert property (s_sw(toe_op_swap_dec) |=> reg_y_out == $past(y_dec) && skip_next == (reg_y_out == 4'hf))
        else $error("swap dec wrong");
    a_swap_inc: assert property (s_sw(toe_op_swap_inc) |=> reg_y_out == $past(y_inc) && skip_next == (reg_y_out == 4'h0))
        else $error("swap inc wrong");
    a_one_cycle: assert property (s_op(toe_op_tmr_six) |=> done && tmr_ctrl[23:20] == $past(acc_in))
        else $error("not done in one cycle");
endmodule // toe_exec_properties
bind toe_exec toe_exec_properties u_toe_exec_properties (.*);

// ---- testbench/transfer_op_execution_bench.sv ----
// self-checking bench for the transfer instruction executor
module transfer_op_execution_bench
    import toe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, op_valid = 0, watchdog_overflow_set = 0;
    logic done, skip_next, acc_we, xy_we, ram_we, reload_three_load, serial_shift_load;
    logic watchdog_overflow_flag, watchdog_stopped;
    logic [9:0] op_code = 0, data_pointer = 0, ram_addr;
    logic [3:0] acc_in = 0, reg_b_in = 0, reg_x_in = 0, reg_y_in = 0, ram_rdata = 0;
    logic [3:0] acc_out, reg_x_out, reg_y_out, ram_wdata, irq_ctrl_one, irq_ctrl_two;
    logic [7:0] reload_reg_three, serial_shift;
    logic [23:0] tmr_ctrl;
    int seed = 32'h02a7043e, bad_count = 0, checked = 0, cyc = 0, n;
    toe_exec u_toe_exec (.*);
    always #25 clk = ~clk;
    task test_done;
        $display("mismatches %0d checks %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task cmp(input string s, input logic [23:0] e, input logic [23:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    function automatic logic [3:0] want_y(logic [9:0] op, logic [3:0] y);
        return op[9:4] == toe_op_swap_dec ? y - 4'h1 : op[9:4] == toe_op_swap_inc ? y + 4'h1 : y;
    endfunction
    task go(input logic [9:0] op, input logic [3:0] y);
        logic [3:0] a, b, x, m;
        logic [9:0] dp;
        logic sk, sw;
        {a, b, x, m} = 16'($random(seed));
        dp = 10'($random(seed));
        sw = op[9:6] == 4'hb;
        sk = (op[9:4] == toe_op_swap_dec && y == 4'h0) || (op[9:4] == toe_op_swap_inc && y == 4'hf);
        @(posedge clk);
        op_valid <= 1;
        op_code <= op;
        acc_in <= a;
        reg_b_in <= b;
        reg_x_in <= x;
        reg_y_in <= y;
        ram_rdata <= m;
        data_pointer <= dp;
        @(posedge clk);
        op_valid <= 0;
        @(negedge clk);
        cmp("done", 1, done);
        cmp("reload_ld", op == toe_op_reload_three, reload_three_load);
        cmp("shift_ld", op == toe_op_serial_shift, serial_shift_load);
        cmp("acc_we", sw, acc_we);
        cmp("ram_we", sw, ram_we);
        cmp("xy_we", sw, xy_we);
        if (op == toe_op_reload_three) cmp("reload", {b, a}, reload_reg_three);
        if (op == toe_op_serial_shift) cmp("shift", {b, a}, serial_shift);
        if (op == toe_op_irq_one) cmp("irq1", a, irq_ctrl_one);
        if (op == toe_op_irq_two) cmp("irq2", a, irq_ctrl_two);
        if (op >= toe_op_tmr_one && op <= toe_op_tmr_six) cmp("tmr", a, tmr_ctrl[(op - toe_op_tmr_one) * 4 +: 4]);
        if (op[9:6] == 4'hb) begin
            cmp("acc", m, acc_out);
            cmp("ram", a, ram_wdata);
            cmp("ram_addr", dp, ram_addr);
            cmp("x", x ^ op[3:0], reg_x_out);
            cmp("y", want_y(op, y), reg_y_out);
        end
        if (op != toe_op_wdog_test) cmp("skip", sk, skip_next);
        $display("test %h done", op);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            test_done;
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        go(toe_op_reload_three, 0);
        go(toe_op_serial_shift, 0);
        go(toe_op_irq_one, 0);
        go(toe_op_irq_two, 0);
        for (n = 0; n < 6; n++) go(toe_op_tmr_one + 10'(n), 0);
        for (n = 0; n < 48; n++) go({n % 3 == 0 ? toe_op_swap : n % 3 == 1 ? toe_op_swap_dec : toe_op_swap_inc,
            4'(n)}, n < 6 ? {4{n[1]}} : 4'($random(seed)));
        go(toe_op_wdog_test, 0);
        cmp("wskip", 0, skip_next);
        @(posedge clk) watchdog_overflow_set <= 1;
        @(posedge clk) watchdog_overflow_set <= 0;
        @(negedge clk) cmp("wflag", 1, watchdog_overflow_flag);
        go(toe_op_wdog_test, 0);
        cmp("wskip", 1, skip_next);
        cmp("wflag", 0, watchdog_overflow_flag);
        cmp("stop", 0, watchdog_stopped);
        @(posedge clk) op_valid <= 1;
        op_code <= toe_op_wdog_disable;
        @(posedge clk) op_code <= toe_op_wdog_test;
        @(negedge clk) cmp("done", 0, done);
        @(posedge clk) op_valid <= 0;
        @(negedge clk) cmp("stop", 1, watchdog_stopped);
        test_done;
    end
endmodule // transfer_op_execution_bench
